// ---- core/servo_defs.svh ----
// servo_defs.svh: offsets, field positions, reset values and timing figures
// assumes a 100 MHz system clock; included by the servo package users
`ifndef SERVO_DEFS_SVH
`define SERVO_DEFS_SVH

`define CLK_MHZ          100
`define CYC_PER_US       (`CLK_MHZ)
`define LONG_PRESS_MS    300
`define DOUBLE_WIN_MS    300
`define DEBOUNCE_MS      5
`define LONG_PRESS_CYC   (`LONG_PRESS_MS * 1000 * `CYC_PER_US)
`define DOUBLE_WIN_CYC   (`DOUBLE_WIN_MS * 1000 * `CYC_PER_US)
`define DEBOUNCE_CYC     (`DEBOUNCE_MS * 1000 * `CYC_PER_US)

`define FRAME_US_50      15'h4e20
`define FRAME_US_125     15'h1f40
`define FRAME_US_250     15'h0fa0
`define FRAME_US_333     15'h0bbb

`define WIDTH_MIN_US     12'h1f4
`define WIDTH_MAX_US     12'h9c4
`define WIDTH_DEF_US     12'h5dc
`define SWEEP_LO_US      12'h3e8
`define SWEEP_HI_US      12'h7d0
`define WIDTH_STEP_US    12'h00a
`define SWEEP_STEP_MIN   6'h01
`define SWEEP_STEP_MAX   6'h32
`define SWEEP_STEP_DEF   6'h05
`define RATE_SEL_DEF     2'h0

`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_WIDTH        4'h8
`define REG_SWEEP        4'hc
`define CTRL_RUN_BIT     0
`define ST_RUN_BIT       0
`define ST_FREQ_BIT      1
`define ST_SWEEP_BIT     2
`define ST_RATE_LSB      3

`endif

// ---- core/servo_pkg.sv ----
// servo_pkg: state types for the servo pulse generator
// assumes servo_defs.svh supplies all numeric figures
package servo_pkg;

  typedef enum logic [1:0] {
    BTN_IDLE  = 2'b00,
    BTN_HELD  = 2'b01,
    BTN_LONG  = 2'b10,
    BTN_WAIT2 = 2'b11
  } btn_state_t;

  typedef struct packed {
    btn_state_t  btn;
    logic [31:0] btn_cnt;
    logic        run;
    logic        edit_freq;
    logic        sweep;
    logic        sweep_up;
    logic [1:0]  rate_sel;
    logic [11:0] width;
    logic [5:0]  sweep_step;
    logic [6:0]  pre;
    logic [14:0] frame_cnt;
    logic        pwm;
    logic [15:0] rdata;
  } servo_state_t;

  typedef struct packed {
    logic        a_s1;
    logic        a_s2;
    logic        b_s1;
    logic        b_s2;
    logic        k_s1;
    logic        k_s2;
    logic        a_prev;
    logic        k_stable;
    logic [31:0] k_cnt;
    logic        cw;
    logic        ccw;
  } cond_state_t;

endpackage : servo_pkg

// ---- core/input_conditioner.sv ----
// input_conditioner: synchronises encoder and button pins, decodes steps,
// debounces the button; assumes pins are asynchronous to clk
`timescale 1ns/100ps
`include "servo_defs.svh"

module input_conditioner #(
  parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic enc_a,
  input  wire logic enc_b,
  input  wire logic button,
  output logic      step_cw,
  output logic      step_ccw,
  output logic      pressed
);
  import servo_pkg::*;

  cond_state_t st;
  cond_state_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.a_s1 = enc_a;
    next_st.a_s2 = st.a_s1;
    next_st.b_s1 = enc_b;
    next_st.b_s2 = st.b_s1;
    next_st.k_s1 = button;
    next_st.k_s2 = st.k_s1;
    next_st.a_prev = st.a_s2;
    // one step per full detent: count on rising edge of channel a only
    next_st.cw  = st.a_s2 && !st.a_prev && !st.b_s2;
    next_st.ccw = st.a_s2 && !st.a_prev && st.b_s2;
    if (st.k_s2 == st.k_stable)
    begin
      next_st.k_cnt = 32'h0;
    end
    else if (st.k_cnt >= 32'(DEBOUNCE_CYC - 1))
    begin
      next_st.k_stable = st.k_s2;
      next_st.k_cnt    = 32'h0;
    end
    else
    begin
      next_st.k_cnt = st.k_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign step_cw  = st.cw;
  assign step_ccw = st.ccw;
  assign pressed  = st.k_stable;

endmodule : input_conditioner

// ---- core/servo_pulse_generator.sv ----
// servo_pulse_generator: servo control pulse with encoder and button editing
// assumes encoder/button pins are asynchronous; button input is high when pressed
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "servo_defs.svh"

module servo_pulse_generator #(
  parameter int LONG_PRESS_CYC = `LONG_PRESS_CYC,
  parameter int DOUBLE_WIN_CYC = `DOUBLE_WIN_CYC,
  parameter int DEBOUNCE_CYC   = `DEBOUNCE_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  input  wire logic        ENC_A,
  input  wire logic        ENC_B,
  input  wire logic        BUTTON,
  output logic             PWM_OUT,
  output logic             EDIT_FREQ,
  output logic             SWEEP_ON,
  output logic             RUNNING
);
  import servo_pkg::*;

  localparam logic [6:0] PRE_LAST = 7'(`CYC_PER_US - 1);

  servo_state_t st;
  servo_state_t next_st;
  logic         step_cw;
  logic         step_ccw;
  logic         pressed;

  input_conditioner #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_cond (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .ce       (CE),
    .enc_a    (ENC_A),
    .enc_b    (ENC_B),
    .button   (BUTTON),
    .step_cw  (step_cw),
    .step_ccw (step_ccw),
    .pressed  (pressed)
  );

  // frame length in microseconds for each rate code
  function automatic logic [14:0] frame_us(input logic [1:0] sel);
    logic [14:0] r;
    r = `FRAME_US_50;
    unique case (sel)
      2'h0: r = `FRAME_US_50;
      2'h1: r = `FRAME_US_125;
      2'h2: r = `FRAME_US_250;
      2'h3: r = `FRAME_US_333;
    endcase
    return r;
  endfunction : frame_us

  // move a width by delta and hold it inside lo..hi
  function automatic logic [11:0] nudge(input logic [11:0] w,
                                        input logic [11:0] delta,
                                        input logic        up,
                                        input logic [11:0] lo,
                                        input logic [11:0] hi);
    logic [12:0] t;
    t = up ? ({1'b0, w} + {1'b0, delta}) : ({1'b0, w} - {1'b0, delta});
    if (!up && (w < lo + delta))
      return lo;
    else if (up && (t > {1'b0, hi}))
      return hi;
    else if (t[11:0] < lo)
      return lo;
    else
      return t[11:0];
  endfunction : nudge

  always_comb
  begin
    logic        tick;
    logic        boundary;
    logic        short_rel;
    logic        long_hit;
    logic        dbl;
    logic [11:0] w;
    tick      = 1'b0;
    boundary  = 1'b0;
    short_rel = 1'b0;
    long_hit  = 1'b0;
    dbl       = 1'b0;
    w         = st.width;
    next_st   = st;

    // prescaler held while stopped so the first microsecond after start is whole
    tick = (st.pre == PRE_LAST);
    if (!st.run)
      next_st.pre = 7'h0;
    else
      next_st.pre = tick ? 7'h0 : st.pre + 7'h1;

    // frame counter; >= guards a shorter frame chosen mid-frame
    if (!st.run)
    begin
      next_st.frame_cnt = 15'h0;
    end
    else if (tick)
    begin
      if (st.frame_cnt >= frame_us(st.rate_sel) - 15'h1)
      begin
        next_st.frame_cnt = 15'h0;
        boundary          = 1'b1;
      end
      else
      begin
        next_st.frame_cnt = st.frame_cnt + 15'h1;
      end
    end

    // button classification: short, long, double
    if (!st.run)
    begin
      next_st.btn     = BTN_IDLE;
      next_st.btn_cnt = 32'h0;
    end
    else
    begin
      unique case (st.btn)
        BTN_IDLE:
        begin
          next_st.btn_cnt = 32'h0;
          if (pressed)
            next_st.btn = BTN_HELD;
        end
        BTN_HELD:
        begin
          if (!pressed)
          begin
            next_st.btn     = BTN_WAIT2;
            next_st.btn_cnt = 32'h0;
          end
          else if (st.btn_cnt >= 32'(LONG_PRESS_CYC - 1))
          begin
            long_hit    = 1'b1;
            next_st.btn = BTN_LONG;
          end
          else
          begin
            next_st.btn_cnt = st.btn_cnt + 32'h1;
          end
        end
        BTN_LONG:
        begin
          if (!pressed)
            next_st.btn = BTN_IDLE;
        end
        BTN_WAIT2:
        begin
          if (pressed)
          begin
            dbl         = 1'b1;
            next_st.btn = BTN_LONG;
          end
          else if (st.btn_cnt >= 32'(DOUBLE_WIN_CYC - 1))
          begin
            // a lone short press only counts once no second press can follow
            short_rel   = 1'b1;
            next_st.btn = BTN_IDLE;
          end
          else
          begin
            next_st.btn_cnt = st.btn_cnt + 32'h1;
          end
        end
      endcase
    end

    if (short_rel)
      next_st.edit_freq = !st.edit_freq;

    if (long_hit)
    begin
      if (st.edit_freq)
      begin
        next_st.sweep    = !st.sweep;
        next_st.sweep_up = 1'b1;
      end
      else
      begin
        w = `WIDTH_DEF_US;
      end
    end

    // encoder steps
    if (st.run && (step_cw || step_ccw))
    begin
      if (st.edit_freq)
      begin
        next_st.rate_sel = step_cw ? st.rate_sel + 2'h1 : st.rate_sel - 2'h1;
      end
      else if (st.sweep)
      begin
        if (step_cw && st.sweep_step < `SWEEP_STEP_MAX)
          next_st.sweep_step = st.sweep_step + 6'h1;
        else if (step_ccw && st.sweep_step > `SWEEP_STEP_MIN)
          next_st.sweep_step = st.sweep_step - 6'h1;
      end
      else
      begin
        w = nudge(st.width, `WIDTH_STEP_US, step_cw, `WIDTH_MIN_US, `WIDTH_MAX_US);
      end
    end

    // sweep ramp: a smaller step per frame gives a longer sweep period
    if (st.sweep && boundary)
    begin
      w = nudge(st.width, {6'h0, st.sweep_step}, st.sweep_up,
                `SWEEP_LO_US, `SWEEP_HI_US);
      if (st.sweep_up && w == `SWEEP_HI_US)
        next_st.sweep_up = 1'b0;
      else if (!st.sweep_up && w == `SWEEP_LO_US)
        next_st.sweep_up = 1'b1;
    end
    next_st.width = w;

    if (dbl)
    begin
      next_st.run       = 1'b0;
      next_st.edit_freq = 1'b0;
    end

    // software start wins over a simultaneous exit
    if (WR && ADDR == `REG_CTRL && WDATA[`CTRL_RUN_BIT])
      next_st.run = 1'b1;
    if (WR && ADDR == `REG_SWEEP && WDATA[5:0] >= `SWEEP_STEP_MIN
        && WDATA[5:0] <= `SWEEP_STEP_MAX)
      next_st.sweep_step = WDATA[5:0];

    // pulse high for the first width microseconds of each frame
    next_st.pwm = next_st.run && ({3'h0, next_st.width} > next_st.frame_cnt);

    next_st.rdata = 16'h0;
    if (RD)
    begin
      unique case (ADDR)
        `REG_CTRL:
          next_st.rdata[`CTRL_RUN_BIT] = st.run;
        `REG_STATUS:
        begin
          next_st.rdata[`ST_RUN_BIT]   = st.run;
          next_st.rdata[`ST_FREQ_BIT]  = st.edit_freq;
          next_st.rdata[`ST_SWEEP_BIT] = st.sweep;
          next_st.rdata[`ST_RATE_LSB +: 2] = st.rate_sel;
        end
        `REG_WIDTH:
          next_st.rdata[11:0] = st.width;
        `REG_SWEEP:
          next_st.rdata[5:0] = st.sweep_step;
        default:
          next_st.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st            <= '0;
      st.btn        <= BTN_IDLE;
      st.sweep_up   <= 1'b1;
      st.rate_sel   <= `RATE_SEL_DEF;
      st.width      <= `WIDTH_DEF_US;
      st.sweep_step <= `SWEEP_STEP_DEF;
    end
    else if (CE)
    begin
      st <= next_st;
    end
  end

  assign RDATA     = st.rdata;
  assign PWM_OUT   = st.pwm;
  assign EDIT_FREQ = st.edit_freq;
  assign SWEEP_ON  = st.sweep;
  assign RUNNING   = st.run;

endmodule : servo_pulse_generator

// ---- verif/servo_chk_props.sv ----
// servo_chk: port assertions for the servo pulse generator
// assumes a 100 MHz CLK_SYS, so 1 us is 100 cycles
`timescale 1ns/100ps
module servo_chk #(
  parameter int LONG_PRESS_CYC = 200,
  parameter int DOUBLE_WIN_CYC = 200,
  parameter int DEBOUNCE_CYC   = 4
) (
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        ENC_A,
  input wire logic        ENC_B,
  input wire logic        BUTTON,
  input wire logic        PWM_OUT,
  input wire logic        EDIT_FREQ,
  input wire logic        SWEEP_ON,
  input wire logic        RUNNING
);
  logic [17:0] hi_cnt;
  logic        rd_ok;
  logic        st_rd;
  logic        start;
  assign rd_ok = RD && CE;
  assign st_rd = rd_ok && ADDR == 4'h4;
  assign start = WR && CE && ADDR == 4'h0 && WDATA[0];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
      hi_cnt <= '0;
    else
      hi_cnt <= PWM_OUT ? hi_cnt + 18'h1 : '0;
  chk_rdata_idle: assert property (!$past(rd_ok) |-> RDATA == 16'h0)
    else $error("read data not idle");
  chk_status_flags: assert property ($past(st_rd) |-> RDATA[0] == $past(RUNNING)
    && RDATA[1] == $past(EDIT_FREQ) && RDATA[2] == $past(SWEEP_ON))
    else $error("status flags wrong");
  chk_start_pulse: assert property ($past(start && !RUNNING) |-> RUNNING && PWM_OUT)
    else $error("start did not raise pulse");
  chk_width_range: assert property ($fell(PWM_OUT) && RUNNING |->
    hi_cnt >= 18'h0c346 && hi_cnt <= 18'h3d09a)
    else $error("pulse width out of range");
  chk_stop_quiet: assert property (!RUNNING && !$past(RUNNING) |-> !PWM_OUT)
    else $error("pulse while stopped");
  chk_idle_hold: assert property (!RUNNING && !$past(RUNNING) |->
    $stable(EDIT_FREQ) && $stable(SWEEP_ON))
    else $error("mode changed while stopped");
  chk_sweep_target: assert property ($changed(SWEEP_ON) && RUNNING |-> $past(EDIT_FREQ))
    else $error("sweep toggled in width target");
  chk_edit_release: assert property ($changed(EDIT_FREQ) && RUNNING |-> !BUTTON)
    else $error("target toggled while pressed");
endmodule : servo_chk
bind servo_pulse_generator servo_chk #(
  .LONG_PRESS_CYC(LONG_PRESS_CYC),
  .DOUBLE_WIN_CYC(DOUBLE_WIN_CYC),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)
) i_chk (.CLK_SYS, .RST_N, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .ENC_A, .ENC_B,
  .BUTTON, .PWM_OUT, .EDIT_FREQ, .SWEEP_ON, .RUNNING);

// ---- verif/servo_load.sv ----
// servo_load: rc servo stand-in that times the control pulse
// assumes the pulse is sampled on the system clock
`timescale 1ns/100ps
module servo_load (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pwm,
  output logic      [31:0] hi_cyc
);
  logic [31:0] cnt;
  // only the last whole pulse is kept, as a servo acts on that
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt    <= '0;
      hi_cyc <= '0;
    end
    else if (pwm)
      cnt <= cnt + 32'h1;
    else if (cnt != '0)
    begin
      hi_cyc <= cnt;
      cnt    <= '0;
    end
endmodule : servo_load

// ---- verif/testbench.sv ----
// testbench: drives the servo generator by bus, encoder and button
// assumes shortened press timings; full frames are too long to wait for
`timescale 1ns/100ps
module testbench;
  logic        CLK_SYS, RST_N, WR, RD, ENC_A, ENC_B, BUTTON;
  logic        PWM_OUT, EDIT_FREQ, SWEEP_ON, RUNNING;
  logic [3:0]  ADDR;
  logic [15:0] WDATA, RDATA;
  logic [31:0] hi_cyc;
  int          n_mismatch, compares;

  servo_pulse_generator #(.LONG_PRESS_CYC(200), .DOUBLE_WIN_CYC(200), .DEBOUNCE_CYC(4))
  i_dut (.CLK_SYS, .RST_N, .CE(1'b1), .ADDR, .WDATA, .WR, .RD, .RDATA, .ENC_A, .ENC_B,
    .BUTTON, .PWM_OUT, .EDIT_FREQ, .SWEEP_ON, .RUNNING);
  servo_load i_load (.clk(CLK_SYS), .rst_n(RST_N), .pwm(PWM_OUT), .hi_cyc);

  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
    @(posedge CLK_SYS);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1 check(nm, {16'h0, RDATA}, {16'h0, exp});
  endtask : rd

  task automatic step(input logic cw, input int n);
    repeat (n)
    begin
      @(posedge CLK_SYS);
      ENC_B <= ~cw;
      repeat (3) @(posedge CLK_SYS);
      ENC_A <= 1'b1;
      repeat (6) @(posedge CLK_SYS);
      ENC_A <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
    end
  endtask : step

  // hold beyond the long-press count, or release well inside it
  task automatic press(input int hold, input int gap);
    @(posedge CLK_SYS);
    BUTTON <= 1'b1;
    repeat (hold) @(posedge CLK_SYS);
    BUTTON <= 1'b0;
    repeat (gap) @(posedge CLK_SYS);
  endtask : press

  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (200000) @(posedge CLK_SYS);
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    {RST_N, WR, RD, ENC_A, ENC_B, BUTTON} = '0;
    ADDR = '0;
    WDATA = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (20) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    rd(4'h4, 16'h0000, "status");
    rd(4'h8, 16'h05dc, "width");
    rd(4'h2, 16'h0000, "unmapped");
    wr(4'h0, 16'h0001);
    #1 check("pwm", PWM_OUT, 32'h1);
    rd(4'h0, 16'h0001, "ctrl run");
    step(1'b0, 102);
    rd(4'h8, 16'h01f4, "width min");
    for (int i = 0; i < 60000 && PWM_OUT === 1'b1; i++)
      @(posedge CLK_SYS);
    @(posedge CLK_SYS);
    #1 check("pulse", hi_cyc >= 49900 && hi_cyc <= 50100, 32'h1);
    step(1'b1, 202);
    rd(4'h8, 16'h09c4, "width max");
    press(300, 20);
    rd(4'h8, 16'h05dc, "width def");
    press(20, 300);
    rd(4'h4, 16'h0003, "freq target");
    #1 check("edit pin", EDIT_FREQ, 32'h1);
    for (int r = 1; r <= 4; r++)
    begin
      step(1'b1, 1);
      rd(4'h4, {11'h0, 2'(r), 3'h3}, "rate");
    end
    step(1'b0, 1);
    rd(4'h4, 16'h001b, "rate down");
    press(300, 20);
    rd(4'h4, 16'h001f, "sweep on");
    #1 check("sweep pin", SWEEP_ON, 32'h1);
    press(20, 300);
    rd(4'h4, 16'h001d, "width target");
    step(1'b0, 1);
    rd(4'hc, 16'h0004, "sweep step");
    rd(4'h8, 16'h05dc, "width kept");
    wr(4'hc, 16'h0033);
    rd(4'hc, 16'h0004, "sweep refused");
    wr(4'hc, 16'h0001);
    rd(4'hc, 16'h0001, "sweep min");
    press(20, 20);
    press(20, 20);
    #1 check("exit", {RUNNING, EDIT_FREQ, PWM_OUT}, 32'h0);
    report_and_stop();
  end
endmodule : testbench
